/* hw/bsso_defines.svh */
`ifndef BSSO_DEFINES_SVH
`define BSSO_DEFINES_SVH

// Instruction word layout
`define BSSO_INSTR_W 16
`define BSSO_OP9_MSB 15
`define BSSO_OP9_LSB 7
`define BSSO_OP8_MSB 15
`define BSSO_OP8_LSB 8
`define BSSO_ADDR_MSB 6
`define BSSO_ADDR_LSB 0
`define BSSO_IMM_MSB 7
`define BSSO_IMM_LSB 4
`define BSSO_WIDX_MSB 3
`define BSSO_WIDX_LSB 0

// Opcode values
`define BSSO_OP9_SKIP_BIT_ONE 9'h111
`define BSSO_OP9_SKIP_BIT_TWO 9'h114
`define BSSO_OP9_SKIP_BIT_THREE 9'h115
`define BSSO_OP9_SUB_MEM_ACC 9'h034
`define BSSO_OP8_SUB_WREG_IMM 8'h1E

// Bit positions tested by the skips
`define BSSO_BIT_ONE 2'h1
`define BSSO_BIT_TWO 2'h2
`define BSSO_BIT_THREE 2'h3

// Reset values and program counter steps
`define BSSO_PC_W 11
`define BSSO_PC_RESET 11'h000
`define BSSO_PC_STEP 11'h001
`define BSSO_PC_SKIP 11'h002
`define BSSO_ACC_RESET 4'h0
`define BSSO_WAKE_RESET 4'hF

`endif

/* hw/bsso_pkg.sv */
package bsso_pkg;

  // Execution state of the core slice
  typedef enum logic {
    BSSO_RUN,
    BSSO_STOP
  } bsso_state_e;

  // Decoded operation class
  typedef enum logic [2:0] {
    BSSO_OP_OTHER,
    BSSO_OP_SKIP_BIT,
    BSSO_OP_STOP,
    BSSO_OP_SUB_MEM,
    BSSO_OP_SUB_WREG
  } bsso_op_e;

  typedef logic [3:0] bsso_nibble_t;

endpackage : bsso_pkg

/* hw/bsso_core.sv */
// Summary of operation
// - Opcode 100010001 with address: PC plus 2 if nibble bit 1 set, else plus 1.
// - Opcode 100010100 with address: PC plus 2 if nibble bit 2 set, else plus 1.
// - Opcode 100010101 with address: PC plus 2 if nibble bit 3 set, else plus 1.
// - Stop instruction halts the oscillator and suspends instruction execution.
// - In stop, a falling edge on the wake-up port resumes at the next instruction.
// - Opcode 000110100: accumulator gets nibble minus accumulator, flags updated, one cycle.
// - Prefix 00011110: accumulator gets working register minus immediate, flags updated.
`timescale 1ns/1ns
`include "bsso_defines.svh"

module bsso_core #(
  parameter logic [15:0] STOP_OPCODE = 16'h0000,
  parameter bit CARRY_IS_NOT_BORROW = 1'b1,
  parameter int WAKE_PINS = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [3:0] mem_nibble_in,
  input wire logic [3:0] wreg_nibble_in,
  input wire logic [WAKE_PINS-1:0] wakeup_input_port_in,
  output logic [10:0] pc_out,
  output logic [3:0] acc_out,
  output logic carry_flag_out,
  output logic zero_flag_out,
  output logic osc_halt_out,
  output logic skip_taken_out,
  output logic exec_done_out
);

  // Four-bit subtract; result bit 4 is the borrow out
  function automatic logic [4:0] sub_nibble(
    input logic [3:0] minuend,
    input logic [3:0] subtrahend
  );
    logic [4:0] wide;
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    sub_nibble = wide;
  endfunction : sub_nibble

  // Carry encoding of a borrow, shared by both subtract forms
  function automatic logic carry_of(
    input logic borrow
  );
    carry_of = CARRY_IS_NOT_BORROW ? ~borrow : borrow;
  endfunction : carry_of

  bsso_pkg::bsso_state_e state_reg;
  bsso_pkg::bsso_op_e op_kind;
  logic [10:0] pc_reg;
  bsso_pkg::bsso_nibble_t acc_reg;
  logic carry_reg;
  logic zero_reg;
  logic skip_reg;
  logic done_reg;
  logic halt_reg;
  logic [WAKE_PINS-1:0] wake_meta_reg;
  logic [WAKE_PINS-1:0] wake_sync_reg;
  logic [WAKE_PINS-1:0] wake_prev_reg;
  logic wake_fall;
  logic [1:0] test_bit;
  logic bit_is_set;
  logic [4:0] sub_res;
  logic executing;

  // Decode the instruction word into an operation class
  always_comb
  begin
    op_kind = bsso_pkg::BSSO_OP_OTHER;
    test_bit = `BSSO_BIT_ONE;
    if (instr_in == STOP_OPCODE)
    begin
      op_kind = bsso_pkg::BSSO_OP_STOP;
    end
    else
    begin
      case (instr_in[`BSSO_OP9_MSB:`BSSO_OP9_LSB])
        `BSSO_OP9_SKIP_BIT_ONE:
        begin
          op_kind = bsso_pkg::BSSO_OP_SKIP_BIT;
          test_bit = `BSSO_BIT_ONE;
        end
        `BSSO_OP9_SKIP_BIT_TWO:
        begin
          op_kind = bsso_pkg::BSSO_OP_SKIP_BIT;
          test_bit = `BSSO_BIT_TWO;
        end
        `BSSO_OP9_SKIP_BIT_THREE:
        begin
          op_kind = bsso_pkg::BSSO_OP_SKIP_BIT;
          test_bit = `BSSO_BIT_THREE;
        end
        `BSSO_OP9_SUB_MEM_ACC:
        begin
          op_kind = bsso_pkg::BSSO_OP_SUB_MEM;
        end
        default:
        begin
          if (instr_in[`BSSO_OP8_MSB:`BSSO_OP8_LSB] == `BSSO_OP8_SUB_WREG_IMM)
          begin
            op_kind = bsso_pkg::BSSO_OP_SUB_WREG;
          end
        end
      endcase
    end
  end

  // Tested bit of the addressed nibble
  assign bit_is_set = mem_nibble_in[test_bit];

  // One subtractor serves both forms; operands chosen by the opcode
  always_comb
  begin
    if (op_kind == bsso_pkg::BSSO_OP_SUB_WREG)
    begin
      sub_res = sub_nibble(wreg_nibble_in, instr_in[`BSSO_IMM_MSB:`BSSO_IMM_LSB]);
    end
    else
    begin
      sub_res = sub_nibble(mem_nibble_in, acc_reg);
    end
  end

  // Instructions are only taken while running
  assign executing = instr_valid_in && (state_reg == bsso_pkg::BSSO_RUN);

  // Wake-up pins come from outside; two flops before any edge logic
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wake_meta_reg <= {WAKE_PINS{1'b1}};
      wake_sync_reg <= {WAKE_PINS{1'b1}};
      wake_prev_reg <= {WAKE_PINS{1'b1}};
    end
    else
    begin
      wake_meta_reg <= wakeup_input_port_in;
      wake_sync_reg <= wake_meta_reg;
      wake_prev_reg <= wake_sync_reg;
    end
  end

  // A high-to-low step on any pin counts as a wake-up edge
  assign wake_fall = |(wake_prev_reg & ~wake_sync_reg);

  // Run/stop state; an edge seen before stop is entered is not remembered
  // The halt output keeps its own flop so the pin sees no decode logic
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= bsso_pkg::BSSO_RUN;
      halt_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        bsso_pkg::BSSO_RUN:
        begin
          if (executing && op_kind == bsso_pkg::BSSO_OP_STOP)
          begin
            state_reg <= bsso_pkg::BSSO_STOP;
            halt_reg <= 1'b1;
          end
        end
        bsso_pkg::BSSO_STOP:
        begin
          if (wake_fall)
          begin
            state_reg <= bsso_pkg::BSSO_RUN;
            halt_reg <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= bsso_pkg::BSSO_RUN;
          halt_reg <= 1'b0;
        end
      endcase
    end
  end

  // Program counter; stop already steps past itself so wake resumes next
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pc_reg <= `BSSO_PC_RESET;
    end
    else if (executing)
    begin
      if (op_kind == bsso_pkg::BSSO_OP_SKIP_BIT && bit_is_set)
      begin
        pc_reg <= pc_reg + `BSSO_PC_SKIP;
      end
      else
      begin
        pc_reg <= pc_reg + `BSSO_PC_STEP;
      end
    end
  end

  // Skip indicator, one cycle, for the fetch logic
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      skip_reg <= executing && op_kind == bsso_pkg::BSSO_OP_SKIP_BIT && bit_is_set;
      done_reg <= executing;
    end
  end

  // Accumulator takes the difference; memory and register are never written
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc_reg <= `BSSO_ACC_RESET;
    end
    else if (executing && (op_kind == bsso_pkg::BSSO_OP_SUB_MEM ||
                           op_kind == bsso_pkg::BSSO_OP_SUB_WREG))
    begin
      acc_reg <= sub_res[3:0];
    end
  end

  // Flags follow the subtract in the same cycle it executes
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
    end
    else if (executing && (op_kind == bsso_pkg::BSSO_OP_SUB_MEM ||
                           op_kind == bsso_pkg::BSSO_OP_SUB_WREG))
    begin
      carry_reg <= carry_of(sub_res[4]);
      zero_reg <= (sub_res[3:0] == 4'h0);
    end
  end

  // Outputs straight from flops
  assign pc_out = pc_reg;
  assign acc_out = acc_reg;
  assign carry_flag_out = carry_reg;
  assign zero_flag_out = zero_reg;
  assign osc_halt_out = halt_reg;
  assign skip_taken_out = skip_reg;
  assign exec_done_out = done_reg;

endmodule : bsso_core

/* tb/bsso_core_properties.sv */
`timescale 1ns/1ns
module bsso_chk #(
  parameter logic [15:0] STOP_OPCODE = 16'h0000,
  parameter int WAKE_PINS = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [3:0] mem_nibble_in,
  input wire logic [3:0] wreg_nibble_in,
  input wire logic [WAKE_PINS-1:0] wakeup_input_port_in,
  input wire logic [10:0] pc_out,
  input wire logic [3:0] acc_out,
  input wire logic carry_flag_out,
  input wire logic zero_flag_out,
  input wire logic osc_halt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Only an awake core takes an instruction
  wire take = instr_valid_in && !osc_halt_out;
  wire sub_r = instr_in[15:7] == 9'h034;
  wire sub_w = instr_in[15:8] == 8'h1e;
  wire [3:0] lhs = sub_r ? mem_nibble_in : wreg_nibble_in;
  wire [3:0] rhs = sub_r ? acc_out : instr_in[7:4];
  // A falling pin seen while stopped
  sequence s_wake_fall;
    osc_halt_out && |($past(wakeup_input_port_in) & ~wakeup_input_port_in);
  endsequence
  property p_skip(op, b);
    take && instr_in[15:7] == op |=>
      pc_out == $past(pc_out) + ($past(mem_nibble_in[b]) ? 11'h002 : 11'h001);
  endproperty
  a_skip_bit_one: assert property (p_skip(9'h111, 1))
    else $error("bit one skip step wrong");
  a_skip_bit_two: assert property (p_skip(9'h114, 2))
    else $error("bit two skip step wrong");
  a_skip_bit_three: assert property (p_skip(9'h115, 3))
    else $error("bit three skip step wrong");
  a_stop_halts: assert property (
    take && instr_in == STOP_OPCODE |=> osc_halt_out && pc_out == $past(pc_out) + 11'h001)
    else $error("stop not entered");
  a_halt_frozen: assert property (osc_halt_out |=> $stable(pc_out) && $stable(acc_out))
    else $error("state moved while stopped");
  a_wake_resume: assert property (s_wake_fall |-> ##[1:4] !osc_halt_out)
    else $error("no wake after pin fall");
  a_sub_mem_acc: assert property (take && sub_r |=> acc_out == $past(lhs - rhs))
    else $error("memory subtract result wrong");
  a_sub_wreg_imm: assert property (take && sub_w |=> acc_out == $past(lhs - rhs))
    else $error("register subtract result wrong");
  a_sub_flags: assert property (take && (sub_r || sub_w) |=>
    carry_flag_out == $past(lhs >= rhs) && zero_flag_out == (acc_out == 4'h0))
    else $error("subtract flags wrong");
endmodule : bsso_chk

bind bsso_core bsso_chk #(.STOP_OPCODE(STOP_OPCODE), .WAKE_PINS(WAKE_PINS)) chk_u (
  .ref_clk_in, .rst_n_in, .instr_valid_in, .instr_in, .mem_nibble_in, .wreg_nibble_in,
  .wakeup_input_port_in, .pc_out, .acc_out, .carry_flag_out, .zero_flag_out, .osc_halt_out);

/* tb/bit_skip_stop_subtract_ops_bench.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module bit_skip_stop_subtract_ops_bench;
  logic ref_clk_in = 0, rst_n_in = 0, instr_valid_in = 0;
  logic [15:0] instr_in = 16'h0000;
  logic [3:0] mem_nibble_in = 4'h0, wreg_nibble_in = 4'h0, wakeup_input_port_in = 4'hf;
  logic [10:0] pc_out, e_pc = 0;
  logic [3:0] acc_out, e_acc = 0, a, b;
  logic carry_flag_out, zero_flag_out, osc_halt_out, skip_taken_out, exec_done_out;
  logic e_c = 0, e_z = 0, e_h = 0, e_s = 0, e_d = 0;
  int bad_count = 0, num_checks = 0, cycles = 0;
  bsso_core dut_u (.ref_clk_in, .rst_n_in, .instr_valid_in, .instr_in, .mem_nibble_in,
    .wreg_nibble_in, .wakeup_input_port_in, .pc_out, .acc_out, .carry_flag_out,
    .zero_flag_out, .osc_halt_out, .skip_taken_out, .exec_done_out);
  initial forever #5 ref_clk_in = ~ref_clk_in;
  // Cut a hang short well past the expected run length
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic skips(logic [15:0] w, logic [3:0] m);
    return (w[15:7] == 9'h111 && m[1]) || (w[15:7] == 9'h114 && m[2])
      || (w[15:7] == 9'h115 && m[3]);
  endfunction : skips
  function automatic logic [15:0] pick();
    logic [8:0] ops [5] = '{9'h111, 9'h114, 9'h115, 9'h034, 9'h1f0};
    logic [15:0] w = {ops[$urandom % 5], 7'($urandom)};
    if ($urandom % 4 == 0) w = {8'h1e, 8'($urandom)};
    return w;
  endfunction : pick
  // Check last cycle's outputs, then present one instruction and predict it
  task automatic step(input logic v, input logic [15:0] w, input logic [3:0] m, r);
    @(negedge ref_clk_in);
    `CHK("pc", e_pc, pc_out)
    `CHK("acc", e_acc, acc_out)
    `CHK("carry", e_c, carry_flag_out)
    `CHK("zero", e_z, zero_flag_out)
    `CHK("halt", e_h, osc_halt_out)
    `CHK("skip", e_s, skip_taken_out)
    `CHK("done", e_d, exec_done_out)
    instr_valid_in = v;
    instr_in = w;
    mem_nibble_in = m;
    wreg_nibble_in = r;
    e_d = v && !e_h;
    e_s = e_d && skips(w, m);
    if (!e_d) return;
    e_pc = e_pc + (e_s ? 11'h002 : 11'h001);
    e_h = w == 16'h0000;
    a = w[15:7] == 9'h034 ? m : r;
    b = w[15:7] == 9'h034 ? e_acc : w[7:4];
    if (w[15:7] == 9'h034 || w[15:8] == 8'h1e)
    begin
      e_acc = a - b;
      e_c = a >= b;
      e_z = e_acc == 4'h0;
    end
  endtask : step
  // Stop, offer a refused instruction, then wake on one pin
  task automatic stop_wake();
    step(1, 16'h0000, 0, 0);
    step(1, {9'h034, 7'h01}, 4'h9, 4'h2);
    step(0, 16'h1234, 0, 0);
    wakeup_input_port_in[$urandom % 4] = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    e_h = 0;
    e_d = 0;
    wakeup_input_port_in = 4'hf;
  endtask : stop_wake
  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Corner cases first, then random traffic with stops mixed in
  initial
  begin
    void'($urandom(90771));
    repeat (3) @(negedge ref_clk_in);
    rst_n_in = 1;
    step(1, {8'h1e, 4'h7, 4'h3}, 0, 4'h7);
    step(1, {8'h1e, 4'hf, 4'h0}, 0, 4'h0);
    step(1, {9'h034, 7'h7f}, 4'h0, 0);
    step(1, {9'h111, 7'h00}, 4'hf, 0);
    step(1, {9'h114, 7'h00}, 4'hb, 0);
    step(1, {9'h115, 7'h00}, 4'h8, 0);
    stop_wake();
    for (int i = 0; i < 600; i++)
    begin
      if (i % 100 == 50) stop_wake();
      step($urandom % 4 != 0, pick(), 4'($urandom), 4'($urandom));
    end
    // Reset while stopped must clear the halt and every register
    step(1, 16'h0000, 0, 0);
    step(0, 16'h1234, 0, 0);
    rst_n_in = 0;
    e_pc = 0;
    e_acc = 0;
    e_c = 0;
    e_z = 0;
    e_h = 0;
    @(negedge ref_clk_in);
    rst_n_in = 1;
    step(1, {9'h111, 7'h05}, 4'h2, 0);
    step(0, 16'h1234, 0, 0);
    summarize();
  end
endmodule : bit_skip_stop_subtract_ops_bench
